// File: logic/break_mask_control.sv
// channel b data mask register and break control register behind an ahb-lite slave
// Notes on behaviour
// RQ1: 32-bit read/write channel b data mask, untouched by any reset.
// RQ2: mask bit one drops that data bit from the compare, zero keeps it.
// RQ3: software writes equal low and second bytes of data and mask for byte breaks.
// RQ4: byte or word size ignores upper sixteen bits of data and mask.
// RQ5: software picks an operand size when channel b data is compared.
// RQ6: 16-bit control register, read/write, reset clears to zero.
// RQ7: bit 15 set on channel a match, cleared only by writing zero.
// RQ8: bit 14 set on channel b match, cleared only by writing zero.
// RQ9: reserved control bits read zero; software writes zero to them.
// RQ10: bit 10 picks channel a fetch break before (0) or after (1) execution.
// RQ11: bit 6 picks channel b fetch break before (0) or after (1) execution.
// RQ12: bit 7 adds masked data compare to channel b condition.
// RQ13: with data excluded software sets channel b fetch/data select to 10 or 11.
// RQ14: bit 3 zero independent; one means b flags only after a matched.
// RQ15: sequential mode: no break if b precedes or coincides with a; a flag stays.
// RQ16: break data ignored on fetch cycles or when data enable is zero.
// RQ17: writing one to a match flag leaves it unchanged.
`timescale 1ns/100ps
module break_mask_control
  import break_ctl_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // channel a result from the address compare
  input wire logic chan_a_cond_hit,
  // channel b raw conditions from the address and bus-cycle compare
  input wire logic chan_b_addr_hit,
  input wire logic [1:0] chan_b_fetch_data_select,
  input wire logic [1:0] chan_b_op_size,
  input wire logic [31:0] cpu_data_bus,
  input wire logic [31:0] channel_b_break_data_value,
  // break requests and timing selects toward the trap logic
  output logic chan_a_break,
  output logic chan_b_break,
  output logic chan_a_fetch_break_timing,
  output logic chan_b_fetch_break_timing
);

  // every register but the mask lives in one bundle, so reset and update stay together
  typedef struct packed {
    logic wr_pend; // a write data phase follows
    logic [7:0] wr_addr; // offset taken at the address phase
    logic [31:0] rdata; // read data held through the data phase
    logic [15:0] control; // break control register
    logic a_seen; // chained mode: channel a has matched, b is armed
    logic a_brk; // channel a break pulse
    logic b_brk; // channel b break pulse
  } state_t;

  // registered state and its next value
  state_t s_q;
  state_t s_d;
  // the mask is kept apart because it must survive every reset
  logic [31:0] channel_b_data_compare_mask_q;
  // decoded break conditions
  logic data_hit;
  logic chan_b_hit;
  logic b_chain_ok;
  logic chained;
  logic a_flag_set;
  logic b_flag_set;
  // bus decode
  logic addr_take;
  logic ctl_wr;
  logic mask_wr;
  logic [15:0] wval;

  // masked data compare, upper half dropped for byte and word sizes
  data_match_b u_match (
    .bus_data(cpu_data_bus),
    .break_data(channel_b_break_data_value),
    .mask(channel_b_data_compare_mask_q),
    .op_size(chan_b_op_size),
    .hit(data_hit)
  );

  // read view of registers; reserved bits come back zero
  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [15:0] c,
                                           input logic [31:0] m);
    if (a == mask_reg_offset) begin
      return m;
    end else if (a == control_reg_offset) begin
      return {16'h0000, c & control_writable | c & 16'hc000}; // see RQ9
    end
    return 32'h0000_0000;
  endfunction

  // a pending data phase aimed at one offset
  function automatic logic wr_hits(input logic pend, input logic [7:0] a,
                                   input logic [7:0] off);
    return pend && (a == off);
  endfunction

  // software write into control; flags only fall on a written zero, never rise
  function automatic logic [15:0] ctl_merge(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = (c & ~control_writable) | (w & control_writable); // see RQ9
    r[match_a_flag_pos] = c[match_a_flag_pos] & w[match_a_flag_pos]; // see RQ7 RQ17
    r[match_b_flag_pos] = c[match_b_flag_pos] & w[match_b_flag_pos]; // see RQ8 RQ17
    return r;
  endfunction

  // address phase accepted; hsize is not checked, whole words only
  assign addr_take = hsel && hready && htrans == htrans_nonseq;
  // data phases that land in a register
  assign ctl_wr = wr_hits(s_q.wr_pend, s_q.wr_addr, control_reg_offset);
  assign mask_wr = wr_hits(s_q.wr_pend, s_q.wr_addr, mask_reg_offset);
  assign wval = hwdata[15:0]; // control only uses the low half
  assign chained = s_q.control[chained_pos];

  // data joins channel b only on data cycles with enable set
  assign chan_b_hit = chan_b_addr_hit && ((!s_q.control[data_cond_pos]) || // see RQ12
                      chan_b_fetch_data_select == fetch_data_fetch || data_hit); // see RQ16
  // a match on a earlier arms b; a same-cycle a hit does not count
  assign b_chain_ok = !chained || s_q.a_seen; // see RQ14
  // in chained mode a only arms b and never raises its own flag
  assign a_flag_set = chan_a_cond_hit && !chained; // see RQ15
  assign b_flag_set = chan_b_hit && b_chain_ok; // see RQ14

  // next state: bus phases, software writes, then hardware sets
  always_comb begin
    s_d = s_q;
    s_d.wr_pend = addr_take && hwrite;
    if (addr_take) begin
      s_d.wr_addr = haddr[7:0];
    end
    // read taken at the address phase: a read right after a write sees the old value
    if (addr_take && !hwrite) begin
      s_d.rdata = read_mux(haddr[7:0], s_q.control, channel_b_data_compare_mask_q);
    end
    if (ctl_wr) begin
      s_d.control = ctl_merge(s_q.control, wval);
    end
    // hardware sets come last so they win over a same-cycle software clear
    if (a_flag_set) begin
      s_d.control[match_a_flag_pos] = 1'b1; // see RQ7 RQ15
    end
    if (b_flag_set) begin
      s_d.control[match_b_flag_pos] = 1'b1; // see RQ8 RQ14
    end
    // arm on a; leaving chained mode drops the arm
    if (chan_a_cond_hit && chained) begin
      s_d.a_seen = 1'b1;
    end
    if (!chained) begin
      s_d.a_seen = 1'b0;
    end
    s_d.a_brk = a_flag_set; // see RQ15
    s_d.b_brk = b_flag_set; // see RQ15
    if (b_flag_set && chained) begin
      s_d.a_seen = 1'b0; // sequence consumed, re-arm needs a new a match
    end
  end

  // control state; reset clears the control register, see RQ6
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{wr_pend: 1'b0, wr_addr: 8'h00, rdata: 32'h0000_0000,
               control: control_reset, a_seen: 1'b0, a_brk: 1'b0, b_brk: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // mask has no reset on purpose, software must load it; see RQ1
  always_ff @(posedge hclk) begin
    if (mask_wr) begin
      channel_b_data_compare_mask_q <= hwdata;
    end
  end

  // zero-wait slave, always okay; no register access ever needs a wait state
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // data outputs straight from flip-flops
  assign hrdata = s_q.rdata;
  assign chan_a_break = s_q.a_brk;
  assign chan_b_break = s_q.b_brk;
  assign chan_a_fetch_break_timing = s_q.control[a_timing_pos]; // see RQ10
  assign chan_b_fetch_break_timing = s_q.control[b_timing_pos]; // see RQ11

  // assertions on the register map

  // reserved bits can never be written to one
  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ9
    (s_q.control & ~(control_writable | 16'hc000)) == 16'h0000)
    else $error("reserved control bits not zero");

  // a control read returns a 16-bit value
  read_ctl_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ6
    addr_take && !hwrite && haddr[7:0] == control_reg_offset |=>
    hrdata[31:16] == 16'h0000)
    else $error("control read upper half not zero");

  // the mask takes the whole written word
  mask_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ1
    mask_wr |=> channel_b_data_compare_mask_q == $past(hwdata))
    else $error("mask register did not take the write");

  // both timing selects follow the written control word
  timing_follow_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ10 RQ11
    ctl_wr |=> chan_a_fetch_break_timing == $past(hwdata[a_timing_pos]) &&
    chan_b_fetch_break_timing == $past(hwdata[b_timing_pos]))
    else $error("timing select did not follow the write");

  // assertions on the match flags

  // an independent channel a match raises its flag
  flag_a_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ7
    chan_a_cond_hit && !chained |=> s_q.control[match_a_flag_pos])
    else $error("channel a flag not set on match");

  // an allowed channel b match raises its flag
  flag_b_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ8
    chan_b_hit && b_chain_ok |=> s_q.control[match_b_flag_pos])
    else $error("channel b flag not set on match");

  // only a control write may drop the a flag
  flag_a_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ17
    s_q.control[match_a_flag_pos] && !ctl_wr
    |=> s_q.control[match_a_flag_pos])
    else $error("channel a flag lost without write");

  // only a written zero may drop the b flag
  flag_b_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ8
    s_q.control[match_b_flag_pos] && !(ctl_wr && hwdata[match_b_flag_pos] == 1'b0)
    |=> s_q.control[match_b_flag_pos])
    else $error("channel b flag lost");

  // a written zero clears the a flag unless a match sets it again
  write_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ7
    ctl_wr && !hwdata[match_a_flag_pos] && !(chan_a_cond_hit && !chained)
    |=> !s_q.control[match_a_flag_pos])
    else $error("channel a flag not cleared by zero");

  // assertions on chained matching

  // chained mode never raises the a flag
  chain_no_a_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ15
    chained && !s_q.control[match_a_flag_pos] && !ctl_wr
    |=> !s_q.control[match_a_flag_pos])
    else $error("channel a flag set in sequential mode");

  // chained mode never breaks on channel a
  chain_no_brk_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ15
    chained |=> !chan_a_break)
    else $error("channel a break in sequential mode");

  // b cannot break before a has armed it
  chain_order_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ14
    chained && !s_q.a_seen |=> !chan_b_break)
    else $error("channel b break before channel a");

  // assertions on the channel b data condition

  // a data mismatch blocks b when data is part of the condition
  data_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ12
    !chained && chan_b_addr_hit && s_q.control[data_cond_pos] &&
    chan_b_fetch_data_select != fetch_data_fetch && !data_hit |=> !chan_b_break)
    else $error("channel b broke on data mismatch");

  // data left out of the condition never blocks b
  data_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ12
    !chained && chan_b_addr_hit && !s_q.control[data_cond_pos] |=> chan_b_break)
    else $error("channel b blocked with data disabled");

  // fetch cycles ignore the break data
  fetch_skip_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ16
    !chained && chan_b_addr_hit && chan_b_fetch_data_select == fetch_data_fetch
    |=> chan_b_break)
    else $error("channel b blocked on fetch cycle");

  // main scenarios
  cov_chain: cover property (@(posedge hclk) disable iff (!hresetn)
    chained && chan_b_break);
  cov_a: cover property (@(posedge hclk) disable iff (!hresetn) chan_a_break);
  cov_clr: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(s_q.control[match_b_flag_pos]));
  cov_data_miss: cover property (@(posedge hclk) disable iff (!hresetn)
    s_q.control[data_cond_pos] && chan_b_addr_hit && !data_hit);
  cov_fetch: cover property (@(posedge hclk) disable iff (!hresetn)
    chan_b_addr_hit && chan_b_fetch_data_select == fetch_data_fetch);
endmodule // break_mask_control

// File: logic/break_ctl_pkg.sv
// shared offsets, field positions and reset values for the break mask/control block
package break_ctl_pkg;
  localparam logic [7:0] mask_reg_offset = 8'h00;
  localparam logic [7:0] control_reg_offset = 8'h04;
  localparam int match_a_flag_pos = 15;
  localparam int match_b_flag_pos = 14;
  localparam int a_timing_pos = 10;
  localparam int data_cond_pos = 7;
  localparam int b_timing_pos = 6;
  localparam int chained_pos = 3;
  localparam logic [15:0] control_reset = 16'h0000;
  localparam logic [15:0] control_writable = 16'h04c8;
  localparam logic [1:0] size_none = 2'h0;
  localparam logic [1:0] size_byte = 2'h1;
  localparam logic [1:0] size_word = 2'h2;
  localparam logic [1:0] fetch_data_fetch = 2'h1;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
endpackage

// File: logic/data_match_b.sv
// masked data comparison for channel b
`timescale 1ns/100ps
module data_match_b
  import break_ctl_pkg::*;
(
  // operands
  input wire logic [31:0] bus_data,
  input wire logic [31:0] break_data,
  input wire logic [31:0] mask,
  input wire logic [1:0] op_size,
  // result
  output logic hit
);
  logic [31:0] diff;
  // a mask bit of one drops that bit from the compare; see RQ2
  always_comb begin
    diff = (bus_data ^ break_data) & ~mask;
    if (op_size == size_byte || op_size == size_word) begin
      diff[31:16] = 16'h0000; // see RQ4
    end
    hit = (diff == 32'h0000_0000);
  end
endmodule // data_match_b

// File: dv/cpu_bus_model.sv
// processor bus cycle model feeding the break compare inputs
`timescale 1ns/100ps
module cpu_bus_model (
  // clock
  input wire logic hclk,
  // monitored cycle
  output logic a_hit,
  output logic b_hit,
  output logic [1:0] sel,
  output logic [1:0] size,
  output logic [31:0] data,
  output logic [31:0] bdata
);
  // quiet bus, data access of long size
  initial begin
    {a_hit, b_hit} = 2'h0;
    {sel, size} = 4'hb;
    {data, bdata} = 64'h0;
  end
  // one monitored cycle; size and select always set by caller
  task automatic cycle(input logic a, input logic b, input logic [1:0] s, input logic [1:0] z,
                       input logic [31:0] d, input logic [31:0] bd);
    @(posedge hclk);
    {a_hit, b_hit, sel, size} <= {a, b, s, z};
    {data, bdata} <= {d, bd};
    @(posedge hclk);
    {a_hit, b_hit} <= 2'h0;
    // released bus shows the inverse so a stale value cannot match
    data <= ~d;
  endtask
endmodule // cpu_bus_model

// File: dv/tb_top.sv
// self-checking bench for the break mask and control registers
`timescale 1ns/100ps
module tb_top;
  import break_ctl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, a_brk, b_brk, a_tim, b_tim, a_hit, b_hit;
  logic [1:0] htrans, sel, size;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, data, bdata, rd;
  int failures, checks;
  always #50 hclk = ~hclk;
  // the one slave's hreadyout is the bus hready
  break_mask_control u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .chan_a_cond_hit(a_hit),
    .chan_b_addr_hit(b_hit), .chan_b_fetch_data_select(sel), .chan_b_op_size(size),
    .cpu_data_bus(data), .channel_b_break_data_value(bdata), .chan_a_break(a_brk),
    .chan_b_break(b_brk), .chan_a_fetch_break_timing(a_tim), .chan_b_fetch_break_timing(b_tim));
  cpu_bus_model u_cpu (.hclk(hclk), .a_hit(a_hit), .b_hit(b_hit), .sel(sel), .size(size),
    .data(data), .bdata(bdata));
  // single ahb-lite transfer; waits on hready, read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, htrans_nonseq, wr, 24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // one monitored cycle, then the break pulses one cycle later
  task automatic cyc(input logic a, input logic b, input logic [1:0] s, input logic [1:0] z,
                     input logic [31:0] d, input logic [31:0] bd, input logic [1:0] exp);
    u_cpu.cycle(a, b, s, z, d, bd);
    #1;
    chk({30'h0, a_brk, b_brk}, {30'h0, exp});
  endtask
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: tests need about a hundred cycles
  initial begin
    #(3000 * 100);
    failures++;
    wrap_up();
  end
  initial begin
    {hclk, hsel, hwrite, hresetn} = 4'h0;
    {htrans, hsize, haddr, hwdata} = {2'h0, hsize_word, 64'h0};
    {failures, checks} = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(control_reg_offset, 32'h0);
    ahb(1'b1, mask_reg_offset, 32'ha5c30ff1);
    rdchk(mask_reg_offset, 32'ha5c30ff1);
    ahb(1'b1, control_reg_offset, 32'hffff);
    rdchk(control_reg_offset, 32'h04c8);
    chk({30'h0, a_tim, b_tim}, 32'h3);
    rdchk(8'h08, 32'h0);
    // mid-run reset clears control but keeps the mask
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(mask_reg_offset, 32'ha5c30ff1);
    rdchk(control_reg_offset, 32'h0);
    $display("test regs done");
    cyc(1'b1, 1'b0, 2'h2, 2'h3, 32'h0, 32'h0, 2'h2);
    rdchk(control_reg_offset, 32'h8000);
    ahb(1'b1, control_reg_offset, 32'h8000);
    rdchk(control_reg_offset, 32'h8000);
    ahb(1'b1, control_reg_offset, 32'h0);
    rdchk(control_reg_offset, 32'h0);
    cyc(1'b0, 1'b1, 2'h2, 2'h3, 32'h1, 32'h0, 2'h1);
    rdchk(control_reg_offset, 32'h4000);
    ahb(1'b1, control_reg_offset, 32'h0);
    rdchk(control_reg_offset, 32'h0);
    $display("test flags done");
    ahb(1'b1, control_reg_offset, 32'h0080);
    ahb(1'b1, mask_reg_offset, 32'h000000ff);
    cyc(1'b0, 1'b1, 2'h2, 2'h3, 32'h12345600, 32'h123456ff, 2'h1);
    cyc(1'b0, 1'b1, 2'h2, 2'h3, 32'h12345700, 32'h123456ff, 2'h0);
    cyc(1'b0, 1'b1, 2'h2, 2'h2, 32'hffff56aa, 32'h000056ff, 2'h1);
    cyc(1'b0, 1'b1, 2'h1, 2'h3, 32'h0, 32'hffffffff, 2'h1);
    ahb(1'b1, mask_reg_offset, 32'h00000f0f);
    cyc(1'b0, 1'b1, 2'h2, 2'h1, 32'hffff5a5a, 32'h00005050, 2'h1);
    $display("test data done");
    ahb(1'b1, control_reg_offset, 32'h0008);
    cyc(1'b0, 1'b1, 2'h2, 2'h3, 32'h0, 32'h0, 2'h0);
    cyc(1'b1, 1'b1, 2'h2, 2'h3, 32'h0, 32'h0, 2'h0);
    cyc(1'b1, 1'b0, 2'h2, 2'h3, 32'h0, 32'h0, 2'h0);
    cyc(1'b0, 1'b1, 2'h2, 2'h3, 32'h0, 32'h0, 2'h1);
    cyc(1'b0, 1'b1, 2'h2, 2'h3, 32'h0, 32'h0, 2'h0);
    rdchk(control_reg_offset, 32'h4008);
    $display("test sequence done");
    wrap_up();
  end
endmodule // tb_top
